//--- vgdt_pkg.sv
// Purpose: Shared constants for the grid timing and dimming generator
// Assumes: 50 MHz system clock, oscillator period emulated by a prescaler
// Notes:   All counts are in half oscillator periods unless named otherwise
`default_nettype none
package vgdt_pkg;
	localparam int          CLK_PERIOD_NS    = 20;
	localparam int          OSC_PERIOD_NS    = 2000;
	localparam int          OSC_HALF_CYC     = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int          FRAME_BITS       = 86;
	localparam int          SEG_BITS         = 84;
	localparam int          SEG_HALF         = 42;
	localparam int          DIM_BITS         = 10;
	localparam int          DIM_REV_LSB      = SEG_BITS - DIM_BITS;
	localparam int          KIND_REV_POS     = FRAME_BITS - 1;
	localparam int          ORIGIN_REV_POS   = FRAME_BITS - 2;
	localparam int          PHASE_BITS       = 12;
	localparam int          POS_BITS         = 11;
	localparam logic [9:0]  DIM_RESET        = 10'h000;
	localparam logic [9:0]  DIM_MAX_LINEAR   = 10'h3F8;
	localparam logic [11:0] ON_MAX_HT        = 12'h7F1;
	localparam logic [11:0] BLANK_LEAD_HT    = 12'h004;
	localparam logic [11:0] PHASE_RESET      = 12'h000;
	localparam logic [10:0] POS_ZERO         = 11'h000;
endpackage
`default_nettype wire

//--- vgdt_link_if.sv
// Purpose: Carries the serial frame from the link domain to the core
// Assumes: Frame is quiet whenever the load line is low
// Notes:   One producer, one consumer
`default_nettype none
interface vgdt_link_if
	import vgdt_pkg::*;
();
	logic [FRAME_BITS-1:0] frame;
	modport link (output frame);
	modport core (input frame);
endinterface
`default_nettype wire

//--- vgdt_link_rx.sv
// Purpose: Serial frame shift register on the link clock
// Assumes: Data is stable around the rising link clock edge
// Notes:   Last bit shifted sits at bit 0; no state change while load is low
`default_nettype none
module vgdt_link_rx
	import vgdt_pkg::*;
(
	input  wire logic    i_link_clk, // Serial shift clock
	input  wire logic    i_rstn,     // Asynchronous reset, active low
	input  wire logic    i_data,     // Serial data pin
	input  wire logic    i_load,     // Load pin, shifting while high
	vgdt_link_if.link    lnk         // Frame towards the core
);
	logic [FRAME_BITS-1:0] shift_reg;
	logic [FRAME_BITS-1:0] shift_next;

	assign shift_next = {shift_reg[FRAME_BITS-2:0], i_data};
	assign lnk.frame  = shift_reg;

	always_ff @(posedge i_link_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			shift_reg <= '0;
		else if (i_load)
			shift_reg <= shift_next;
	end
endmodule
`default_nettype wire

//--- vgdt_core.sv
// Purpose: Grid scan, digital dimming and cascade timing for a two-grid display
// Assumes: Frame register is quiet after the load line falls
// Notes:   Grid period is 2048 oscillator periods, tracked in half periods
// Contract
// - A segment frame enables display even when no dimming code was loaded.
// - Grid period equals 2048 oscillator periods.
// - Grid on-time is code/2048 of the period for codes up to 0x3F8.
// - Code zero keeps grids off; 0x3F9 to 0x3FE give 1016.5/2048.
// - Master when role_select is low, slave when role_select is high.
// - Slave aligns its segment halves to the master's grid phase output.
// - Trailing kind bit high means dimming code LSB first, low segment data.
// - Segments stay low until the first segment frame, then display turns on.
`default_nettype none
module vgdt_core
	import vgdt_pkg::*;
#(
	parameter int OSC_HALF = OSC_HALF_CYC        // System clocks per half oscillator period
)
(
	input  wire logic                i_clk,                // System clock
	input  wire logic                i_rstn,               // Asynchronous reset, active low
	input  wire logic                i_ce,                 // Clock enable, freezes system clock state when low; link shifting continues
	input  wire logic                i_link_clk,           // Serial shift clock from controller
	input  wire logic                i_data,               // Serial data pin
	input  wire logic                i_load,               // Load pin
	input  wire logic                i_cascade_sync_in,    // Grid phase from master
	input  wire logic                i_role_select,        // High selects slave role
	output logic                     o_grid_drive_first,   // First grid on
	output logic                     o_grid_drive_second,  // Second grid on
	output logic [SEG_HALF-1:0]      o_segment_drive,      // Segment outputs
	output logic                     o_grid_phase,         // High while second grid is active
	output logic                     o_display_on,         // Segment data present
	output logic [DIM_BITS-1:0]      o_dim_code            // Current dimming code
);

	////////////////////////////////////////////////////////////////////////////
	// Link domain and frame crossing

	vgdt_link_if lnk ();

	vgdt_link_rx u_rx (
		.i_link_clk (i_link_clk),
		.i_rstn     (i_rstn),
		.i_data     (i_data),
		.i_load     (i_load),
		.lnk        (lnk)
	);

	function automatic logic [FRAME_BITS-1:0] vgdt_reverse(input logic [FRAME_BITS-1:0] v);
		logic [FRAME_BITS-1:0] r;
		r = '0;
		for (int i = 0; i < FRAME_BITS; i++)
			r[i] = v[FRAME_BITS-1-i];
		return r;
	endfunction

	logic load_s1_reg;
	logic load_s2_reg;
	logic load_s3_reg;
	logic sync_s1_reg;
	logic sync_s2_reg;
	logic sync_s3_reg;
	logic role_s1_reg;
	logic role_s2_reg;

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			load_s1_reg <= 1'b0;
			load_s2_reg <= 1'b0;
			load_s3_reg <= 1'b0;
			sync_s1_reg <= 1'b0;
			sync_s2_reg <= 1'b0;
			sync_s3_reg <= 1'b0;
			role_s1_reg <= 1'b0;
			role_s2_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			load_s1_reg <= i_load;
			load_s2_reg <= load_s1_reg;
			load_s3_reg <= load_s2_reg;
			sync_s1_reg <= i_cascade_sync_in;
			sync_s2_reg <= sync_s1_reg;
			sync_s3_reg <= sync_s2_reg;
			role_s1_reg <= i_role_select;
			role_s2_reg <= role_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame decode

	logic [FRAME_BITS-1:0] frame_rev;
	logic                  load_fall;
	logic                  is_slave;
	logic                  frame_kind_bit;
	logic                  frame_origin_bit;
	logic                  frame_ours;
	logic                  take_dim;
	logic                  take_seg;
	logic [DIM_BITS-1:0]   frame_dim;
	logic [SEG_BITS-1:0]   frame_seg;

	assign frame_rev        = vgdt_reverse(lnk.frame);
	assign load_fall        = load_s3_reg & ~load_s2_reg;
	assign is_slave         = role_s2_reg;
	assign frame_kind_bit   = frame_rev[KIND_REV_POS];
	assign frame_origin_bit = frame_rev[ORIGIN_REV_POS];
	assign frame_ours       = (frame_origin_bit == is_slave);
	assign take_dim         = load_fall & frame_ours & frame_kind_bit;
	assign take_seg         = load_fall & frame_ours & ~frame_kind_bit;
	assign frame_dim        = frame_rev[DIM_REV_LSB +: DIM_BITS];
	assign frame_seg        = frame_rev[SEG_BITS-1:0];

	logic [DIM_BITS-1:0] dim_reg;
	logic [SEG_BITS-1:0] seg_reg;
	logic                enable_reg;

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			dim_reg    <= DIM_RESET;
			seg_reg    <= '0;
			enable_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			if (take_dim)
				dim_reg <= frame_dim;
			if (take_seg)
			begin
				seg_reg    <= frame_seg;
				enable_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Oscillator emulation and grid phase

	logic [15:0]           pre_reg;
	logic [PHASE_BITS-1:0] phase_reg;
	logic [PHASE_BITS-1:0] phase_next;
	logic                  tick;
	logic                  sync_edge;
	logic                  half;
	logic [POS_BITS-1:0]   pos;

	assign tick       = (pre_reg == 16'(OSC_HALF - 1));
	assign sync_edge  = is_slave & (sync_s2_reg ^ sync_s3_reg);
	// Slave restarts its half on each master phase edge
	assign phase_next = sync_edge ? {sync_s2_reg, POS_ZERO} :
	                    tick      ? phase_reg + 12'h001 : phase_reg;
	assign half       = phase_reg[PHASE_BITS-1];
	assign pos        = phase_reg[POS_BITS-1:0];

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pre_reg   <= '0;
			phase_reg <= PHASE_RESET;
		end
		else if (i_ce)
		begin
			pre_reg   <= (tick || sync_edge) ? 16'h0000 : pre_reg + 16'h0001;
			phase_reg <= phase_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Dimming window

	logic [PHASE_BITS-1:0] on_len;
	logic [PHASE_BITS-1:0] pos_ext;
	logic                  grid_on;

	// Codes above the linear range saturate, the invalid all-ones code included
	assign on_len  = (dim_reg > DIM_MAX_LINEAR) ? ON_MAX_HT :
	                 {1'b0, dim_reg, 1'b0};
	assign pos_ext = {1'b0, pos};
	assign grid_on = (pos_ext >= BLANK_LEAD_HT) &&
	                 (pos_ext < (BLANK_LEAD_HT + on_len));

	////////////////////////////////////////////////////////////////////////////
	// Output registers

	logic [SEG_HALF-1:0] seg_sel;

	assign seg_sel = half ? seg_reg[SEG_BITS-1:SEG_HALF] : seg_reg[SEG_HALF-1:0];

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_grid_drive_first  <= 1'b0;
			o_grid_drive_second <= 1'b0;
			o_segment_drive     <= '0;
			o_grid_phase        <= 1'b0;
			o_display_on        <= 1'b0;
			o_dim_code          <= DIM_RESET;
		end
		else if (i_ce)
		begin
			o_grid_drive_first  <= grid_on & ~half;
			o_grid_drive_second <= grid_on & half;
			o_segment_drive     <= enable_reg ? seg_sel : '0;
			o_grid_phase        <= half;
			o_display_on        <= enable_reg;
			o_dim_code          <= dim_reg;
		end
	end

endmodule
`default_nettype wire

//--- vgdt_mcu.sv
// Purpose: Controller model loading serial frames
// Assumes: Link clock of 48 ns, still between frames
// Notes:   Top frame bit goes out first
`default_nettype none
module vgdt_mcu
	import vgdt_pkg::*;
(
	output logic o_link_clk, // Shift clock
	output logic o_data,     // Serial data
	output logic o_load      // Load strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		o_link_clk = 1'b0;
		o_data     = 1'b0;
		o_load     = 1'b0;
	end
	task automatic send(input logic [FRAME_BITS-1:0] f);
		#7;
		o_load = 1'b1;
		#100;
		for (int i = FRAME_BITS - 1; i >= 0; i--)
		begin
			o_data = f[i];
			#24;
			o_link_clk = 1'b1;
			#24;
			o_link_clk = 1'b0;
		end
		#100;
		o_load = 1'b0;
		o_data = ~o_data;
		#1000;
	endtask
endmodule
`default_nettype wire

//--- vgdt_core_chk.sv
// Purpose: Port assertions for the grid core
// Assumes: OSC_HALF equals the instance value
// Notes:   Half period counts enabled clocks only
`default_nettype none
module vgdt_core_chk
	import vgdt_pkg::*;
#(
	parameter int OSC_HALF = OSC_HALF_CYC // Clocks per half tick
)
(
	input wire logic                i_clk,               // Clock
	input wire logic                i_rstn,              // Reset
	input wire logic                i_ce,                // Enable
	input wire logic                i_cascade_sync_in,   // Phase in
	input wire logic                i_role_select,       // Slave
	input wire logic                o_grid_drive_first,  // Grid one
	input wire logic                o_grid_drive_second, // Grid two
	input wire logic [SEG_HALF-1:0] o_segment_drive,     // Segments
	input wire logic                o_grid_phase,        // Phase
	input wire logic                o_display_on,        // Display
	input wire logic [DIM_BITS-1:0] o_dim_code           // Dim code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] per_reg;
	logic        ph_reg;
	wire         flip = i_ce && (o_grid_phase != ph_reg);
	wire         on = o_grid_drive_first || o_grid_drive_second;
	wire  [15:0] per_next = i_role_select ? 16'h0 : flip ? 16'h1 : per_reg + {15'h0, per_reg != 16'h0};
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ph_reg  <= 1'b0;
			per_reg <= 16'h0;
		end
		else if (i_ce)
		begin
			ph_reg  <= o_grid_phase;
			per_reg <= per_next;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	a_half_period: assert property (flip && per_reg != 16'h0 |-> per_reg == 16'(2048 * OSC_HALF))
		else $error("half period wrong");
	a_lead_blank: assert property ($changed(o_grid_phase) |-> (!on) [*8])
		else $error("grid on in lead");
	a_zero_dark: assert property ((o_dim_code == 10'h0) [*3] |-> !on)
		else $error("grid on at zero code");
	a_grids_apart: assert property (!(o_grid_drive_first && o_grid_drive_second))
		else $error("both grids on");
	a_grid_half: assert property (on |-> o_grid_phase == o_grid_drive_second)
		else $error("grid in wrong half");
	a_seg_dark: assert property (!o_display_on |-> o_segment_drive == '0)
		else $error("segments lit early");
	a_display_held: assert property (o_display_on |=> o_display_on)
		else $error("display dropped");
	a_slave_follow: assert property (i_role_select [*8] ##0 $changed(i_cascade_sync_in) |->
		##[2:6] o_grid_phase == i_cascade_sync_in) else $error("slave not aligned");
	c_disp: cover property ($rose(o_display_on));
	c_grid_drive_second: cover property ($rose(o_grid_drive_second));
	c_slave: cover property (i_role_select && $changed(o_grid_phase));
endmodule
bind vgdt_core vgdt_core_chk #(.OSC_HALF(OSC_HALF)) i_vgdt_core_chk (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_ce(i_ce), .i_cascade_sync_in(i_cascade_sync_in), .i_role_select(i_role_select),
	.o_grid_drive_first(o_grid_drive_first), .o_grid_drive_second(o_grid_drive_second),
	.o_segment_drive(o_segment_drive), .o_grid_phase(o_grid_phase), .o_display_on(o_display_on),
	.o_dim_code(o_dim_code));
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the grid core
// Assumes: OSC_HALF of 2 keeps the run short
// Notes:   Expected values come from the bench model
`default_nettype none
module tb_top
	import vgdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         OH = 2;
	logic                  clk, rstn, ce, lclk, dat, ld, sync, role, g1, g2, ph, don;
	logic [SEG_HALF-1:0]   seg;
	logic [DIM_BITS-1:0]   dim;
	logic [SEG_BITS-1:0]   s_exp;
	logic [FRAME_BITS-1:0] fr;
	logic [DIM_BITS-1:0]   cv [$] = '{10'h000, 10'h001, 10'h3F8, 10'h3F9, 10'h3FE, 10'h000};
	int                    num_errors, n_checks, seed, n, m, d;
	vgdt_core #(.OSC_HALF(OH)) i_vgdt_core (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_link_clk(lclk),
		.i_data(dat), .i_load(ld), .i_cascade_sync_in(sync), .i_role_select(role), .o_grid_drive_first(g1),
		.o_grid_drive_second(g2), .o_segment_drive(seg), .o_grid_phase(ph), .o_display_on(don), .o_dim_code(dim));
	vgdt_mcu i_vgdt_mcu (.o_link_clk(lclk), .o_data(dat), .o_load(ld));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [SEG_BITS-1:0] e, input logic [SEG_BITS-1:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
			num_errors++;
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wph(input logic v);
		for (int i = 0; ph !== v; i++)
		begin
			if (i > 9000)
			begin
				num_errors++;
				close_out();
			end
			@(negedge clk);
		end
	endtask
	task automatic seg_frame();
		s_exp = SEG_BITS'({$random(seed), $random(seed), $random(seed)});
		for (int k = 0; k < SEG_BITS; k++)
			fr[FRAME_BITS-1-k] = s_exp[k];
		fr[1:0] = 2'b00;
		i_vgdt_mcu.send(fr);
		chk("disp", 1, don);
		for (int p = 0; p < 2; p++)
		begin
			wph(p[0]);
			chk("seg", s_exp[p*SEG_HALF +: SEG_HALF], seg);
		end
	endtask
	task automatic dim_frame(input logic [DIM_BITS-1:0] c, input logic h);
		fr = FRAME_BITS'({$random(seed), $random(seed), $random(seed)});
		for (int k = 0; k < DIM_BITS; k++)
			fr[11-k] = c[k];
		fr[1:0] = 2'b01;
		i_vgdt_mcu.send(fr);
		chk("dim", c, dim);
		wph(~h);
		wph(h);
		n = 0;
		m = 0;
		// Count the active grid of half h and the idle one over a whole half
		repeat (2048 * OH)
		begin
			@(negedge clk);
			n += h ? g2 : g1;
			m += h ? g1 : g2;
		end
		d = (c > 10'h3F8) ? 2033 * OH : 2 * OH * c;
		chk("duty", d, n);
		chk("idle", 0, m);
	endtask
	initial
	begin
		seed       = 32'hce8816db;
		num_errors = 0;
		n_checks   = 0;
		rstn       = 1'b0;
		ce         = 1'b1;
		sync       = 1'b0;
		role       = 1'b0;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		wph(1'b1);
		chk("disp", 0, don);
		chk("seg", 0, seg);
		seg_frame();
		cv[5] = DIM_BITS'($unsigned($random(seed)) % 1017);
		foreach (cv[i])
			dim_frame(cv[i], i[0]);
		ce = 1'b0;
		fr = FRAME_BITS'({dim, ph, g1, g2, seg});
		repeat (300) @(negedge clk);
		chk("freeze", fr[SEG_BITS-1:0], {dim, ph, g1, g2, seg});
		ce = 1'b1;
		seg_frame();
		role = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			repeat (40) @(negedge clk);
			sync = ~sync;
			repeat (10) @(negedge clk);
			chk("slave", sync, ph);
			chk("sseg", s_exp[sync*SEG_HALF +: SEG_HALF], seg);
		end
		role = 1'b0;
		close_out();
	end
endmodule
`default_nettype wire
